/* rtl/osd_pkg.sv */
// Shared constants for the on-screen display serial command link.
package osd_pkg;

	// Byte framing on the link.
	localparam int unsigned BYTE_BITS = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Host side serial clock generation, in system clock cycles.
	localparam logic [3:0] SCLK_HALF = 4'h4;
	localparam logic [3:0] CS_GAP = 4'h6;

	// First-byte command patterns.
	localparam logic [1:0] CMD_CHAR_PFX = 2'h3;
	localparam logic [5:0] CMD_INIT_PFX = 6'h2d;
	localparam logic [7:0] CMD_TEST = 8'hb0;
	localparam logic [6:0] CMD_BANK_PFX = 7'h48;

	// Attribute field positions in the first byte of a character write.
	localparam int unsigned ATTR_SWAP = 5;
	localparam int unsigned ATTR_RED = 4;
	localparam int unsigned ATTR_BLUE = 2;
	localparam int unsigned ATTR_BLINK_MIRROR = 1;
	localparam int unsigned ATTR_CH2 = 0;

	// Field position of the blink or mirror select in the initial status second byte.
	localparam int unsigned INIT_MIRROR_SEL = 6;

	// Reserved character codes, the same in both banks.
	localparam logic [7:0] CODE_DISPLAY_OFF = 8'hfe;
	localparam logic [7:0] CODE_END = 8'hff;

	// Screen geometry for the write cursor.
	localparam logic [4:0] COL_LAST = 5'h1b;
	localparam logic [3:0] ROW_LAST = 4'hb;

	// Values after reset.
	localparam logic RST_MIRROR_SEL = 1'h0;
	localparam logic RST_BANK = 1'h0;
	localparam logic [7:0] RST_TEST_CODE = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INIT2,
		ST_TEST2,
		ST_CHAR2,
		ST_SUCC
	} osd_dev_state_t;

	typedef enum logic [2:0] {
		HS_IDLE,
		HS_LOW,
		HS_HIGH,
		HS_NEXT,
		HS_GAP
	} osd_host_state_t;

endpackage

/* rtl/osd_link_if.sv */
// Serial command link between the host controller and the display device.
`timescale 1ns/1ps
interface osd_link_if;
	logic cs_n;
	logic sclk;
	logic sdata;

	modport host
	(
		output cs_n,
		output sclk,
		output sdata
	);

	modport device
	(
		input cs_n,
		input sclk,
		input sdata
	);
endinterface

/* rtl/osd_host.sv */
// Host end: sends bytes over the chip-select framed serial link.
`timescale 1ns/1ps
module osd_host
	import osd_pkg::*;
(
	// System clock and reset.
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// Transfer configuration.
	input wire logic I_LSB_FIRST,
	// Byte request.
	input wire logic I_VALID,
	input wire logic [7:0] I_DATA,
	input wire logic I_LAST,
	output logic O_READY,
	// Link.
	osd_link_if.host LINK
);

	osd_host_state_t state_ff;
	logic [7:0] shift_ff;
	logic last_ff;
	logic [2:0] bit_ff;
	logic [3:0] cnt_ff;
	logic ready_ff;
	logic cs_n_ff;
	logic sclk_ff;
	logic sdata_ff;
	logic take;

	assign take = ready_ff & I_VALID;

	// The clock idles low; data is set up in the low phase and the device samples
	// on the rising edge. Chip select stays low between bytes of one frame.
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			state_ff <= HS_IDLE;
			shift_ff <= 8'h00;
			last_ff <= 1'h0;
			bit_ff <= 3'h0;
			cnt_ff <= 4'h0;
			ready_ff <= 1'h0;
			cs_n_ff <= 1'h1;
			sclk_ff <= 1'h0;
			sdata_ff <= 1'h0;
		end
		else
		begin
			case (state_ff)
				HS_IDLE, HS_NEXT:
				begin
					ready_ff <= ~take;
					if (take)
					begin
						cs_n_ff <= 1'h0;
						shift_ff <= I_DATA;
						last_ff <= I_LAST;
						bit_ff <= 3'h0;
						cnt_ff <= SCLK_HALF;
						sdata_ff <= I_LSB_FIRST ? I_DATA[0] : I_DATA[7];
						state_ff <= HS_LOW;
					end
				end
				HS_LOW:
				begin
					if (cnt_ff == 4'h1)
					begin
						sclk_ff <= 1'h1;
						cnt_ff <= SCLK_HALF;
						state_ff <= HS_HIGH;
					end
					else
					begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				HS_HIGH:
				begin
					if (cnt_ff == 4'h1)
					begin
						sclk_ff <= 1'h0;
						// The last bit of a frame loads the select-high gap instead.
						cnt_ff <= (bit_ff == BIT_LAST && last_ff) ? CS_GAP : SCLK_HALF;
						if (bit_ff == BIT_LAST)
						begin
							if (last_ff)
							begin
								state_ff <= HS_GAP;
							end
							else
							begin
								// Successive bytes keep the frame open.
								ready_ff <= 1'h1;
								state_ff <= HS_NEXT;
							end
						end
						else
						begin
							bit_ff <= bit_ff + 3'h1;
							if (I_LSB_FIRST)
							begin
								shift_ff <= {1'h0, shift_ff[7:1]};
								sdata_ff <= shift_ff[1];
							end
							else
							begin
								shift_ff <= {shift_ff[6:0], 1'h0};
								sdata_ff <= shift_ff[6];
							end
							state_ff <= HS_LOW;
						end
					end
					else
					begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				HS_GAP:
				begin
					// Chip select is held high long enough for the device to see it.
					cs_n_ff <= 1'h1;
					if (cnt_ff == 4'h1)
					begin
						ready_ff <= 1'h1;
						state_ff <= HS_IDLE;
					end
					else
					begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				default:
				begin
					state_ff <= HS_IDLE;
				end
			endcase
		end
	end

	// The gap counter is reloaded for chip-select high time on the last bit of a frame.
	assign O_READY = ready_ff;
	assign LINK.cs_n = cs_n_ff;
	assign LINK.sclk = sclk_ff;
	assign LINK.sdata = sdata_ff;

endmodule

/* rtl/osd_device.sv */
// Device end: serial command intake, successive character writes and attributes.
//
// How it works
// - Mirror only while screen-wide mirroring is on.
// - Shared attribute bit means blink or mirror.
// - Per-character colour applies to colour channel only.
// - Colour swap only while screen-wide swap enabled.
// - Decode test command with fixed upper byte.
// - Test pin low blocks test mode.
// - Host keeps select low across two-byte commands.
// - Extra character bytes reuse latched attributes.
// - Select high or end code ends successive mode.
// - End code leaves successive mode without select.
// - Successive writes stay within the chosen bank.
// - Codes FE and FF are reserved.
// - Display-off data never shows background.
// - Nine-bit code addresses 512 glyphs.
// - Host should raise select between commands.
// - Cursor advances, wraps columns and rows.
`timescale 1ns/1ps
module osd_device
	import osd_pkg::*;
(
	// System clock and reset.
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// Configuration pins.
	input wire logic I_TEST_PIN,
	input wire logic I_LSB_FIRST,
	input wire logic I_MIRROR_EN,
	input wire logic I_SWAP_EN,
	// Link.
	osd_link_if.device LINK,
	// Character write strobe with its data.
	output logic O_WR_STB,
	output logic [3:0] O_WR_ROW,
	output logic [4:0] O_WR_COL,
	output logic [8:0] O_WR_CODE,
	output logic [2:0] O_WR_RGB,
	output logic O_WR_BLINK,
	output logic O_WR_MIRROR,
	output logic O_WR_SWAP,
	output logic O_WR_CH2,
	output logic O_WR_OFF,
	output logic O_WR_BG_EN,
	// Test mode.
	output logic O_TEST_MODE,
	output logic [7:0] O_TEST_CODE
);

	// Link clock domain.
	logic lsb_meta_ff;
	logic lsb_link_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] byte_ff;
	// The link domain has no reset of its own, so the toggle starts from a known level.
	logic byte_tgl_ff = 1'h0;
	logic [7:0] assembled;

	always_ff @(posedge LINK.sclk)
	begin
		lsb_meta_ff <= I_LSB_FIRST;
		lsb_link_ff <= lsb_meta_ff;
	end

	assign assembled = lsb_link_ff ? {LINK.sdata, shift_ff[7:1]} : {shift_ff[6:0], LINK.sdata};

	// The link clock stops between frames, so the frame's own select clears the
	// bit count; a partial byte is dropped when select rises.
	always_ff @(posedge LINK.sclk or posedge LINK.cs_n)
	begin
		if (LINK.cs_n)
		begin
			bit_cnt_ff <= 3'h0;
		end
		else
		begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge LINK.sclk)
	begin
		shift_ff <= assembled;
		if (bit_cnt_ff == BIT_LAST)
		begin
			byte_ff <= assembled;
			byte_tgl_ff <= ~byte_tgl_ff;
		end
	end

	// System clock domain: crossings.
	logic [2:0] tgl_sync_ff;
	logic [2:0] cs_sync_ff;
	logic [2:0] pin_meta_ff;
	logic [2:0] pin_ff;
	logic byte_evt;
	logic frame_end;
	logic [7:0] rx_byte;

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			tgl_sync_ff <= 3'h0;
			cs_sync_ff <= 3'h7;
			pin_meta_ff <= 3'h0;
			pin_ff <= 3'h0;
		end
		else
		begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], byte_tgl_ff};
			cs_sync_ff <= {cs_sync_ff[1:0], LINK.cs_n};
			pin_meta_ff <= {I_SWAP_EN, I_MIRROR_EN, I_TEST_PIN};
			pin_ff <= pin_meta_ff;
		end
	end

	// The byte register is stable for many system cycles after its toggle lands.
	assign byte_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];
	assign frame_end = cs_sync_ff[1] & ~cs_sync_ff[2];
	assign rx_byte = byte_ff;

	// Command decoding.
	osd_dev_state_t state_ff;
	logic in_char;
	logic do_write;

	assign in_char = (state_ff == ST_CHAR2) || (state_ff == ST_SUCC);
	assign do_write = byte_evt & in_char & (rx_byte != CODE_END);

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			state_ff <= ST_IDLE;
		end
		else if (frame_end)
		begin
			state_ff <= ST_IDLE;
		end
		else if (byte_evt)
		begin
			case (state_ff)
				ST_IDLE:
				begin
					if (rx_byte[7:6] == CMD_CHAR_PFX)
					begin
						state_ff <= ST_CHAR2;
					end
					else if (rx_byte[7:2] == CMD_INIT_PFX)
					begin
						state_ff <= ST_INIT2;
					end
					else if (rx_byte == CMD_TEST)
					begin
						state_ff <= ST_TEST2;
					end
				end
				ST_CHAR2, ST_SUCC:
				begin
					// The end code returns to expecting a full first byte.
					state_ff <= (rx_byte == CODE_END) ? ST_IDLE : ST_SUCC;
				end
				default:
				begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Screen-wide settings and latched character attributes.
	logic mirror_sel_ff;
	logic bank_ff;
	logic bank_lat_ff;
	logic [5:0] attr_ff;

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			mirror_sel_ff <= RST_MIRROR_SEL;
			bank_ff <= RST_BANK;
			bank_lat_ff <= RST_BANK;
			attr_ff <= 6'h00;
		end
		else if (byte_evt)
		begin
			if (state_ff == ST_INIT2)
			begin
				mirror_sel_ff <= rx_byte[INIT_MIRROR_SEL];
			end
			else if (state_ff == ST_IDLE && rx_byte[7:6] == CMD_CHAR_PFX)
			begin
				attr_ff <= rx_byte[5:0];
				bank_lat_ff <= bank_ff;
			end
			else if (state_ff == ST_IDLE && rx_byte[7:1] == CMD_BANK_PFX)
			begin
				bank_ff <= rx_byte[0];
			end
		end
	end

	// Write cursor.
	logic [3:0] row_ff;
	logic [4:0] col_ff;

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			row_ff <= 4'h0;
			col_ff <= 5'h00;
		end
		else if (do_write)
		begin
			if (col_ff == COL_LAST)
			begin
				col_ff <= 5'h00;
				row_ff <= (row_ff == ROW_LAST) ? 4'h0 : row_ff + 4'h1;
			end
			else
			begin
				col_ff <= col_ff + 5'h01;
			end
		end
	end

	// Write strobe. Composite channels keep their fixed colour downstream; only
	// the colour channel takes the per-character field.
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			O_WR_STB <= 1'h0;
			O_WR_ROW <= 4'h0;
			O_WR_COL <= 5'h00;
			O_WR_CODE <= 9'h000;
			O_WR_RGB <= 3'h0;
			O_WR_BLINK <= 1'h0;
			O_WR_MIRROR <= 1'h0;
			O_WR_SWAP <= 1'h0;
			O_WR_CH2 <= 1'h0;
			O_WR_OFF <= 1'h0;
			O_WR_BG_EN <= 1'h0;
		end
		else
		begin
			O_WR_STB <= do_write;
			if (do_write)
			begin
				O_WR_ROW <= row_ff;
				O_WR_COL <= col_ff;
				O_WR_CODE <= {bank_lat_ff, rx_byte};
				O_WR_RGB <= attr_ff[ATTR_RED:ATTR_BLUE];
				O_WR_BLINK <= attr_ff[ATTR_BLINK_MIRROR] & ~mirror_sel_ff;
				O_WR_MIRROR <= attr_ff[ATTR_BLINK_MIRROR] & mirror_sel_ff & pin_ff[1];
				O_WR_SWAP <= attr_ff[ATTR_SWAP] & pin_ff[2];
				O_WR_CH2 <= attr_ff[ATTR_CH2];
				O_WR_OFF <= (rx_byte == CODE_DISPLAY_OFF);
				O_WR_BG_EN <= (rx_byte != CODE_DISPLAY_OFF);
			end
		end
	end

	// Test mode.
	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			O_TEST_MODE <= 1'h0;
			O_TEST_CODE <= RST_TEST_CODE;
		end
		else if (byte_evt && state_ff == ST_TEST2 && !frame_end && pin_ff[0])
		begin
			O_TEST_MODE <= 1'h1;
			O_TEST_CODE <= rx_byte;
		end
	end

endmodule

/* dv/osd_link_properties.sv */
// Checker for the wire behaviour of the serial command link.
`timescale 1ns/1ps
module osd_link_properties
(
	// System clock and reset.
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// Link signals.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdata
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	// Bits clocked in this frame, modulo one byte.
	logic [2:0] bit_cnt_ff;
	always_ff @(posedge I_CLK)
		if (I_SYS_RST || cs_n)
			bit_cnt_ff <= 3'h0;
		else if ($rose(sclk))
			bit_cnt_ff <= bit_cnt_ff + 3'h1;

	sclk_idle_low_a: assert property (cs_n |-> !sclk)
		else $error("link clock runs outside a frame");
	sclk_high_width_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("link clock high phase has the wrong length");
	sclk_low_width_a: assert property ($fell(sclk) |-> !sclk[*4])
		else $error("link clock low phase too short");
	data_hold_a: assert property (sclk |-> $stable(sdata))
		else $error("serial data moved while the link clock was high");
	frame_start_a: assert property ($fell(cs_n) |-> !sclk[*4] ##1 sclk)
		else $error("first bit not set up before the link clock");
	whole_byte_a: assert property ($rose(cs_n) |-> bit_cnt_ff == 3'h0)
		else $error("select released in the middle of a byte");
	frame_gap_a: assert property ($rose(cs_n) |-> cs_n[*6])
		else $error("select high gap between frames too short");
	reset_idle_a: assert property (disable iff (1'b0) I_SYS_RST |=> cs_n && !sclk)
		else $error("link not idle during reset");
endmodule

/* dv/osd_serial_command_intake_bench.sv */
// Self-checking bench joining host and device over the serial link.
`timescale 1ns/1ps
module osd_serial_command_intake_bench
	import osd_pkg::*;
();
	logic clk = 0;
	logic rst = 1;
	logic lsb = 0, valid = 0, last = 0, tpin = 0, mir = 0, swp = 0;
	logic [7:0] data = 8'h00;
	logic rdy, stb, blink, mirror, swap, ch2, off, bg, tmode;
	logic [3:0] row, er = 4'h0;
	logic [4:0] col, ec = 5'h0;
	logic [8:0] code;
	logic [2:0] rgb;
	logic [7:0] tcode;
	logic [27:0] wq[$];
	int n_errors = 0, n_checks = 0;
	osd_link_if link();
	osd_host i_osd_host (.I_CLK(clk), .I_SYS_RST(rst), .I_LSB_FIRST(lsb), .I_VALID(valid),
		.I_DATA(data), .I_LAST(last), .O_READY(rdy), .LINK(link.host));
	osd_device i_osd_device (.I_CLK(clk), .I_SYS_RST(rst), .I_TEST_PIN(tpin),
		.I_LSB_FIRST(lsb), .I_MIRROR_EN(mir), .I_SWAP_EN(swp), .LINK(link.device),
		.O_WR_STB(stb), .O_WR_ROW(row), .O_WR_COL(col), .O_WR_CODE(code), .O_WR_RGB(rgb),
		.O_WR_BLINK(blink), .O_WR_MIRROR(mirror), .O_WR_SWAP(swap), .O_WR_CH2(ch2),
		.O_WR_OFF(off), .O_WR_BG_EN(bg), .O_TEST_MODE(tmode), .O_TEST_CODE(tcode));
	osd_link_properties i_osd_link_properties (.I_CLK(clk), .I_SYS_RST(rst),
		.cs_n(link.cs_n), .sclk(link.sclk), .sdata(link.sdata));

	initial
		forever #4 clk = ~clk;

	// The strobe lasts one cycle, so it is captured where it is settled.
	always @(negedge clk)
		if (stb === 1'b1)
			wq.push_back({row, col, code, rgb, blink, mirror, swap, ch2, off, bg});

	task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic send(input logic [7:0] d, input logic l);
		int n = 0;
		@(negedge clk);
		valid = 1;
		data = d;
		last = l;
		while (rdy !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		valid = 0;
	endtask

	task automatic drain();
		int n = 0;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	// Flags are blink, mirror, swap, second channel, display off, background.
	task automatic expw(input logic [8:0] c, input logic [2:0] g, input logic [5:0] f);
		logic [27:0] seen;
		seen = (wq.size() != 0) ? wq.pop_front() : 28'hx;
		check("write", seen, {er, ec, c, g, f});
		if (ec == COL_LAST)
		begin
			ec = 5'h0;
			er = (er == ROW_LAST) ? 4'h0 : er + 4'h1;
		end
		else
			ec = ec + 5'h1;
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		n_errors++;
		give_verdict();
	end

	initial
	begin
		repeat (12) @(negedge clk);
		rst = 0;
		send(8'he7, 0);
		send(8'h10, 0);
		send(8'hfe, 0);
		send(8'hff, 0);
		send(8'hc0, 0);
		send(8'h20, 1);
		drain();
		expw(9'h010, 3'h1, 6'b100101);
		expw(9'h0fe, 3'h1, 6'b100110);
		expw(9'h020, 3'h0, 6'b000001);
		check("extra writes", 28'(wq.size()), 28'h0);
		$display("successive write test done");
		mir = 1;
		swp = 1;
		send(8'hb4, 0);
		send(8'h40, 1);
		send(8'he2, 0);
		send(8'h33, 1);
		drain();
		expw(9'h033, 3'h0, 6'b011001);
		mir = 0;
		swp = 0;
		send(8'he2, 0);
		send(8'h34, 1);
		drain();
		expw(9'h034, 3'h0, 6'b000001);
		$display("attribute test done");
		send(8'h91, 1);
		send(8'hdc, 0);
		for (int i = 0; i < 340; i++)
			send(8'(i % 200), i == 339);
		send(8'h41, 1);
		drain();
		for (int i = 0; i < 340; i++)
			expw({1'b1, 8'(i % 200)}, 3'h7, 6'b000001);
		check("writes after frame end", 28'(wq.size()), 28'h0);
		$display("bank and cursor test done");
		send(8'hb0, 0);
		send(8'h5a, 1);
		drain();
		check("test mode pin low", {27'h0, tmode}, 28'h0);
		tpin = 1;
		send(8'hb0, 1);
		send(8'h3c, 1);
		drain();
		check("test mode aborted", {27'h0, tmode}, 28'h0);
		lsb = 1;
		send(8'h00, 1);
		send(8'hb0, 0);
		send(8'ha5, 1);
		drain();
		check("test mode code", {19'h0, tmode, tcode}, {19'h0, 1'b1, 8'ha5});
		$display("test mode test done");
		give_verdict();
	end
endmodule
